// >>> chan_switch_pkg.sv
// Purpose: Shared constants and types for the channel switch target logic
// Assumes: Single upstream bus, four downstream channels
// Notes:   Address high bits are a parameter; straps give the low two bits
package chan_switch_pkg;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int CHAN_W = 4;
    localparam int BYTE_W = 8;
    localparam int SYNC_W = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [4:0] SYNC_RST = 5'h1f;
    localparam logic [7:0] SHIFT_RST = 8'hff;

    // ------------------------------------------------------------
    // Address layout: five fixed bits then the two strap bits
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED = 5'h1c;

    // ------------------------------------------------------------
    // Positions in the synchronised pin vector
    // ------------------------------------------------------------
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_RSTN = 2;
    localparam int SY_A0 = 3;
    localparam int SY_A1 = 4;

    // ------------------------------------------------------------
    // Bit slot counts within one nine-clock byte slot
    // ------------------------------------------------------------
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_END = 4'h9;

    // ------------------------------------------------------------
    // Serial interface states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_write,
        st_read,
        st_ignore
    } i2c_state_type;

endpackage : chan_switch_pkg

// >>> pin_sync.sv
// Purpose: Two-stage synchroniser for the slow upstream pins
// Assumes: Inputs are levels from outside the system clock domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [chan_switch_pkg::SYNC_W-1:0] async_in,
    output logic [chan_switch_pkg::SYNC_W-1:0] sync_out
);
    import chan_switch_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } sync_state_type;

    sync_state_type r;
    sync_state_type n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.meta = async_in;
        n.stable = r.meta;
    end

    // ------------------------------------------------------------
    // Registers, idle bus levels at reset
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r.meta <= SYNC_RST;
            r.stable <= SYNC_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign sync_out = r.stable;

endmodule : pin_sync

// >>> chan_switch.sv
// Purpose: Bus target of a four-channel switch with one control byte
// Assumes: sys_clk far faster than the upstream clock; open-drain data
// Notes:   Upstream clock shifts data in its own domain; framing and
//          answers run on sys_clk from synchronised pin copies
//
// Behaviour
// - Last address bit: 1 means read, 0 means write.
// - After acknowledged write address, next byte goes to control register.
// - Several written bytes: each overwrites, last one is kept.
// - Control register can be written and read back over the bus.
// - Only the four low bits of the byte pick channels.
// - New selection connects channels only at a STOP condition.
// - Each select bit drives its own channel; any mix allowed.
`timescale 1ns/1ps
module chan_switch
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic reset_pin_n,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    output logic [chan_switch_pkg::CHAN_W-1:0] chan_connect
);
    import chan_switch_pkg::*;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BYTE_W-1:0] shift;
    } link_state_type;

    typedef struct packed {
        i2c_state_type st;
        logic [3:0] cnt;
        logic [BYTE_W-1:0] ctrl;
        logic [CHAN_W-1:0] chan;
        logic pend;
        logic rw;
        logic ack_me;
        logic [BYTE_W-1:0] tx;
        logic sda_oe_n;
        logic dout;
        logic scl_q;
        logic sda_q;
    } core_state_type;

    link_state_type lr;
    link_state_type ln;
    core_state_type r;
    core_state_type n;
    logic [SYNC_W-1:0] sy;
    logic scl_s;
    logic sda_s;
    logic pin_rst;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic addr_hit;
    logic [6:0] own_addr;
    logic [BYTE_W-1:0] link_word;

    // ------------------------------------------------------------
    // Link domain: bits shifted in on each upstream clock rise
    // ------------------------------------------------------------
    always_comb
    begin
        ln = lr;
        ln.shift = {lr.shift[BYTE_W-2:0], sda_in};
    end

    always_ff @(posedge scl_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lr.shift <= SHIFT_RST;
        end
        else
        begin
            lr <= ln;
        end
    end

    // Word is stable through the high phase when the core reads it
    assign link_word = lr.shift;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in({addr_strap_high, addr_strap_low, reset_pin_n, sda_in,
                   scl_clk}),
        .sync_out(sy)
    );

    // Edge and condition decode on synchronised copies
    assign scl_s = sy[SY_SCL];
    assign sda_s = sy[SY_SDA];
    assign pin_rst = ~sy[SY_RSTN];
    assign rise = scl_s & ~r.scl_q;
    assign fall = ~scl_s & r.scl_q;
    assign start_c = scl_s & r.scl_q & r.sda_q & ~sda_s;
    assign stop_c = scl_s & r.scl_q & ~r.sda_q & sda_s;
    assign own_addr = {ADDR_FIXED, sy[SY_A1], sy[SY_A0]};
    assign addr_hit = (link_word[7:1] == own_addr);

    // ------------------------------------------------------------
    // Core framing, acknowledge and register logic
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.scl_q = scl_s;
        n.sda_q = sda_s;
        n.dout = 1'b0;
        if (pin_rst)
        begin
            // Reset pin clears all but the direction bit and read shift; power-on clears those too
            n.st = st_idle;
            n.cnt = CNT_ZERO;
            n.ctrl = CTRL_RST;
            n.chan = CHAN_RST;
            n.pend = 1'b0;
            n.ack_me = 1'b0;
            n.sda_oe_n = 1'b1;
        end
        else if (start_c)
        begin
            // Address byte expected after every START
            n.st = st_addr;
            n.cnt = CNT_ZERO;
            n.ack_me = 1'b0;
            n.sda_oe_n = 1'b1;
        end
        else if (stop_c)
        begin
            n.st = st_idle;
            n.cnt = CNT_ZERO;
            n.ack_me = 1'b0;
            n.sda_oe_n = 1'b1;
            if (r.pend)
            begin
                // Only the low nibble, one bit per channel
                n.chan = r.ctrl[CHAN_W-1:0];
                n.pend = 1'b0;
            end
        end
        else if (rise)
        begin
            if (r.cnt == CNT_LAST)
            begin
                n.cnt = CNT_ACK;
                unique case (r.st)
                    st_addr:
                    begin
                        if (addr_hit)
                        begin
                            n.rw = link_word[0];
                            n.ack_me = 1'b1;
                        end
                        else
                        begin
                            n.st = st_ignore;
                        end
                    end
                    st_write:
                    begin
                        // Every byte overwrites; the last one stays
                        n.ctrl = link_word;
                        n.pend = 1'b1;
                        n.ack_me = 1'b1;
                    end
                    st_read, st_idle, st_ignore:
                    begin
                        n.ack_me = 1'b0;
                    end
                endcase
            end
            else if (r.cnt == CNT_ACK)
            begin
                n.cnt = CNT_END;
                // Controller not acknowledging ends the read
                if (r.st == st_read && sda_s)
                begin
                    n.st = st_ignore;
                end
            end
            else if (r.cnt < CNT_LAST)
            begin
                n.cnt = r.cnt + 4'h1;
            end
        end
        else if (fall)
        begin
            if (r.cnt == CNT_ACK)
            begin
                // Pull low for acknowledge, else release
                n.sda_oe_n = ~r.ack_me;
            end
            else if (r.cnt == CNT_END)
            begin
                n.cnt = CNT_ZERO;
                n.ack_me = 1'b0;
                n.sda_oe_n = 1'b1;
                if (r.st == st_addr)
                begin
                    n.st = r.rw ? st_read : st_write;
                end
                if ((r.st == st_addr && r.rw) || r.st == st_read)
                begin
                    // Load register contents, first bit out now
                    n.sda_oe_n = r.ctrl[BYTE_W-1];
                    n.tx = {r.ctrl[BYTE_W-2:0], 1'b0};
                end
            end
            else if (r.st == st_read && r.cnt != CNT_ZERO)
            begin
                n.sda_oe_n = r.tx[BYTE_W-1];
                n.tx = {r.tx[BYTE_W-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Core registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r.st <= st_idle;
            r.cnt <= CNT_ZERO;
            r.ctrl <= CTRL_RST;
            r.chan <= CHAN_RST;
            r.pend <= 1'b0;
            r.rw <= 1'b0;
            r.ack_me <= 1'b0;
            r.tx <= CTRL_RST;
            r.sda_oe_n <= 1'b1;
            r.dout <= 1'b0;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs straight from flip-flops
    assign sda_out = r.dout;
    assign sda_oe_n = r.sda_oe_n;
    assign chan_connect = r.chan;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    rw_capture_a: assert property (
        (r.st == st_addr && rise && r.cnt == CNT_LAST && addr_hit
            && !pin_rst)
        |=> (r.rw == $past(link_word[0])) && !r.sda_oe_n == 1'b0
    ) else $error("direction bit not captured");

    read_path_a: assert property (
        (r.st == st_addr && fall && r.cnt == CNT_END && r.rw && !pin_rst)
        |=> (r.st == st_read) && (r.sda_oe_n == $past(r.ctrl[7]))
    ) else $error("read did not start with register msb");

    ctrl_write_a: assert property (
        (r.st == st_write && rise && r.cnt == CNT_LAST && !pin_rst)
        |=> (r.ctrl == $past(link_word)) && r.pend
    ) else $error("write byte not stored");

    write_ack_a: assert property (
        (r.st == st_write && fall && r.cnt == CNT_ACK && !pin_rst)
        |=> !r.sda_oe_n
    ) else $error("written byte not acknowledged");

    sel_apply_a: assert property (
        (stop_c && r.pend && !pin_rst)
        |=> (r.chan == $past(r.ctrl[3:0])) && !r.pend
    ) else $error("selection not applied at stop");

    sel_hold_a: assert property (
        (!stop_c && !pin_rst) |=> (r.chan == $past(r.chan))
    ) else $error("channels changed without stop");

    pin_reset_a: assert property (
        pin_rst |=> (r.ctrl == CTRL_RST) && (r.chan == CHAN_RST)
            && (r.st == st_idle) && r.sda_oe_n
    ) else $error("reset pin did not clear state");

    foreign_addr_a: assert property (
        (r.st == st_addr && rise && r.cnt == CNT_LAST && !addr_hit
            && !pin_rst)
        |=> (r.st == st_ignore) ##1 (r.sda_oe_n && r.ctrl == $past(r.ctrl))
    ) else $error("foreign address disturbed the switch");

    ignore_quiet_a: assert property (
        (r.st == st_ignore) |-> r.sda_oe_n
    ) else $error("data driven while ignoring");

    chan_bits_a: assert property (
        $rose(r.chan[2]) |-> $past(r.ctrl[2]) && $past(stop_c)
    ) else $error("channel bit set without its select bit");

endmodule : chan_switch

// >>> i2c_ctrl_model.sv
// Purpose: Behavioural upstream bus controller driving the channel switch
// Assumes: Open-drain data with pull-up; this model owns the bus clock
// Notes:   Half bit time is ten system clocks, well above sampling needs
`timescale 1ns/1ps
module i2c_ctrl_model
(
    input wire logic sys_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);

    // ------------------------------------------------------------
    // Idle bus: clock high, data released to the pull-up
    // ------------------------------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One half bit, paced on the system clock falling edge
    task automatic hp;
        repeat (10) @(negedge sys_clk);
    endtask : hp

    // Start: data falls while clock high; address byte follows
    task automatic start_cond;
        sda_low = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask : start_cond

    // Stop: data rises while clock high, then bus stays free
    task automatic stop_cond;
        sda_low = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_low = 1'b0;
        hp();
    endtask : stop_cond

    // One bit: set data while low, sample at end of high phase
    task automatic one_bit(input logic b, output logic r);
        sda_low = ~b;
        hp();
        scl = 1'b1;
        hp();
        r = sda_wire;
        scl = 1'b0;
    endtask : one_bit

    // Whole byte, most significant bit first, then acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--)
            one_bit(tx[i], rx[i]);
        one_bit(ack_tx, ack_rx);
    endtask : xfer

endmodule : i2c_ctrl_model

// >>> tb_chan_switch.sv
// Purpose: Self-checking bench for the channel switch bus target
// Assumes: Straps fixed, controller model paces the bus clock
// Notes:   Selection is checked before and after the two-byte write's stop, after each later write's stop; read stops go unchecked
`timescale 1ns/1ps
module tb_chan_switch;
    import chan_switch_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP = 2'b10;
    logic sys_clk = 1'b0;
    logic sys_rst;
    logic reset_pin_n;
    logic sda_oe_n;
    logic sda_out;
    logic scl;
    logic sda_low;
    logic [3:0] chan_connect;
    logic [7:0] rx;
    logic ak;
    logic [7:0] sel [5] = '{8'h01, 8'h82, 8'h44, 8'h08, 8'hff};
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    wire logic sda_wire;

    // Open-drain wire: low if either side pulls, else pull-up
    assign sda_wire = sda_oe_n & ~sda_low;

    always #25 sys_clk = ~sys_clk;

    chan_switch i_chan_switch (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .scl_clk(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .reset_pin_n(reset_pin_n),
        .addr_strap_low(STRAP[0]), .addr_strap_high(STRAP[1]),
        .chan_connect(chan_connect));

    i2c_ctrl_model i_i2c_ctrl_model (.sys_clk(sys_clk),
        .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // Address byte with direction in the last bit
    function automatic logic [7:0] adr(input logic rw);
        return {ADDR_FIXED, STRAP, rw};
    endfunction : adr

    // Send one byte and compare the acknowledge seen on the wire
    task automatic put(input string what, input logic [7:0] d,
                       input logic exp_ack);
        i_i2c_ctrl_model.xfer(d, 1'b1, rx, ak);
        chk(what, {7'h0, exp_ack}, {7'h0, ak});
    endtask : put

    task automatic wr_reg(input logic [7:0] v);
        i_i2c_ctrl_model.start_cond();
        put("write address ack", adr(1'b0), 1'b0);
        put("data ack", v, 1'b0);
        i_i2c_ctrl_model.stop_cond();
    endtask : wr_reg

    // Read one byte, ended by a not-acknowledge
    task automatic rd_reg(input logic [7:0] exp);
        i_i2c_ctrl_model.start_cond();
        put("read address ack", adr(1'b1), 1'b0);
        i_i2c_ctrl_model.xfer(8'hff, 1'b1, rx, ak);
        chk("read data", exp, rx);
        chk("drive level", 8'h00, {7'h0, sda_out});
        i_i2c_ctrl_model.stop_cond();
    endtask : rd_reg

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        reset_pin_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("connect after reset", 8'h00, {4'h0, chan_connect});
        rd_reg(CTRL_RST);
        // Two bytes in one write; connection waits for stop
        i_i2c_ctrl_model.start_cond();
        put("write address ack", adr(1'b0), 1'b0);
        put("first data ack", 8'h3c, 1'b0);
        put("last data ack", 8'hf6, 1'b0);
        chk("connect before stop", 8'h00, {4'h0, chan_connect});
        i_i2c_ctrl_model.stop_cond();
        chk("connect after stop", 8'h06, {4'h0, chan_connect});
        rd_reg(8'hf6);
        // Controller acknowledges the first byte, so a copy follows
        i_i2c_ctrl_model.start_cond();
        put("read address ack", adr(1'b1), 1'b0);
        i_i2c_ctrl_model.xfer(8'hff, 1'b0, rx, ak);
        chk("first read byte", 8'hf6, rx);
        i_i2c_ctrl_model.xfer(8'hff, 1'b1, rx, ak);
        chk("second read byte", 8'hf6, rx);
        i_i2c_ctrl_model.stop_cond();
        // Each channel alone, upper bits noisy for channels 1 and 2, then all four
        foreach (sel[i])
        begin
            wr_reg(sel[i]);
            chk("select", {4'h0, sel[i][3:0]},
                {4'h0, chan_connect});
        end
        // Foreign address: no acknowledge, nothing changes
        i_i2c_ctrl_model.start_cond();
        put("foreign address", {ADDR_FIXED, ~STRAP, 1'b0}, 1'b1);
        put("foreign data", 8'h00, 1'b1);
        i_i2c_ctrl_model.stop_cond();
        chk("connect kept", 8'h0f, {4'h0, chan_connect});
        rd_reg(8'hff);
        // Reset pin drops the selection and the register
        reset_pin_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        reset_pin_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk("connect after pin", 8'h00, {4'h0, chan_connect});
        rd_reg(CTRL_RST);
        summarize();
    end

endmodule : tb_chan_switch
